// ### logic/gvp_pkg.sv
// Package with register map, link message layout and state record of the virtual port link.
package gvp_pkg;

  localparam int NPINS = 8;

  // Register byte addresses on the APB side.
  localparam logic [7:0] ADDR_STATE  = 8'h00;
  localparam logic [7:0] ADDR_LINKEN = 8'h04;
  localparam logic [7:0] ADDR_OUTEN  = 8'h08;
  localparam logic [7:0] ADDR_INVERT = 8'h0C;
  localparam logic [7:0] ADDR_MAP0   = 8'h10;
  localparam logic [7:0] ADDR_MAP7   = 8'h2C;
  localparam logic [3:0] MAP_INDEX0  = 4'h4;

  // Reset values of the software registers.
  localparam logic [7:0] RST_PORTS   = 8'h00;
  localparam logic [7:0] RST_CFG     = 8'h00;

  // Default wait for the combined reject answer after a clear query, in cycles.
  localparam logic [7:0] QUERY_WAIT_CYC = 8'h10;

  // Link message kinds.
  localparam logic [1:0] CMD_NONE   = 2'h0;
  localparam logic [1:0] CMD_UPDATE = 2'h1;
  localparam logic [1:0] CMD_CLRQ   = 2'h2;

  typedef enum logic [1:0] {
    FSM_IDLE  = 2'h1,
    FSM_QUERY = 2'h2
  } gvp_fsm_t;

  typedef struct packed {
    logic       cmdValid;
    logic [1:0] cmdKind;
    logic [7:0] cmdData;
    logic       reqValid;
    logic [7:0] reqSet;
    logic [7:0] reqClr;
    logic       respValid;
    logic [7:0] respReject;
  } gvp_link_t;

  typedef struct packed {
    logic clockOutOneEnable;
    logic clockOutTwoEnable;
    logic serialTxZeroEnable;
    logic serialTxOneEnable;
    logic receiveOnSecondTxPin;
    logic serialRxZeroEnable;
    logic serialRxOneEnable;
    logic pdmInputZeroEnable;
    logic pdmInputOneEnable;
    logic pdmAlternateClock;
    logic reducedRateStrobeEnable;
  } gvp_altfn_t;

  typedef struct packed {
    gvp_fsm_t        fsm;
    logic [7:0]      virtualPortState;
    logic [7:0]      remotePinLinkEnable;
    logic [7:0]      pinOutputEnable;
    logic [7:0]      remotePinInvert;
    logic [7:0][7:0] pinPortMap;
    logic [7:0]      sync1;
    logic [7:0]      sync2;
    logic [7:0]      prevLocal;
    logic [7:0]      pendClr;
    logic [7:0]      queryMask;
    logic [7:0]      rejAcc;
    logic [7:0]      waitCnt;
    gvp_link_t       linkOut;
    logic [7:0]      pinOut;
    logic [7:0]      pinOeN;
    logic [31:0]     prdata;
  } gvp_state_t;

endpackage

// ### logic/gvp_link.sv
// Virtual port link: pins of a node mapped onto eight shared one-bit ports.
//
// Operation
// - The master keeps eight one-bit virtual ports, readable together as one byte.
// - Once configured, pin changes travel over the link without host accesses.
// - Inputs mapped to one port combine as a logical OR across nodes.
// - Pin 0 is never linkable on a master, always on a slave; pins 1-2 need clocks off.
// - Pins 3 to 7 are linkable only while their alternate functions are off.
// - A pin takes part only while its link-enable bit is set.
// - Each pin has an 8-bit map; bit k maps it to port k, several allowed.
// - A linked pin takes its direction only from output-enable; input-enable is ignored.
// - Output-enable 1 makes a linked pin an output, 0 an input.
// - A linked input updates every port selected by its map.
// - A linked output drives the OR of the port bits its map selects.
// - The port state register is read-only; writes leave it unchanged.
// - Inversion applies before the port for inputs, after the OR for outputs.
// - Setting a low port makes the master send an update to every node.
// - Clearing a high port sends a clear query; a reject keeps only the rejected ports.
// - With no reject the master sends the updated port value to all nodes.
`timescale 1ns/1ps
module gvp_link
  import gvp_pkg::*;
#(
  parameter logic [7:0] QUERY_WAIT = QUERY_WAIT_CYC
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Node role and alternate pin functions
  input  wire logic        nodeIsMaster,
  input  wire gvp_altfn_t  altFn,
  // Pins and the ordinary pin path for unlinked pins
  input  wire logic [7:0]  pinIn,
  output logic      [7:0]  pinOut,
  output logic      [7:0]  pinOeN,
  input  wire logic [7:0]  plainPinOut,
  input  wire logic [7:0]  plainPinDrive,
  // Bus link messages
  input  wire gvp_link_t   linkIn,
  output gvp_link_t        linkOut
);

  // Pins are released during reset so no output fights the board before configuration.
  localparam gvp_state_t STATE_RST = '{fsm: FSM_IDLE, pinOeN: 8'hFF, default: '0};

  gvp_state_t st;
  gvp_state_t nxt;

  logic [7:0] avail;
  logic [7:0] linked;
  logic [7:0] drvBits;
  logic [7:0] dirBits;
  logic [8:0][7:0] orChain;
  logic [7:0] localIn;
  logic [7:0] masterSet;
  logic [7:0] masterClr;
  logic [7:0] slaveSet;
  logic [7:0] slaveClr;
  logic [7:0] remoteSet;
  logic [7:0] remoteClr;
  logic [7:0] clearBits;
  logic       apbSetup;
  logic       apbAccess;
  logic       mapHit;
  logic [2:0] mapIdx;

  // Pin availability follows the role and what the pin's alternate functions claim.
  assign avail[0] = ~nodeIsMaster;
  assign avail[1] = ~altFn.clockOutOneEnable;
  assign avail[2] = ~altFn.clockOutTwoEnable;
  assign avail[3] = ~altFn.serialTxZeroEnable;
  assign avail[4] = ~(altFn.serialTxOneEnable | altFn.receiveOnSecondTxPin);
  assign avail[5] = ~(altFn.serialRxZeroEnable | altFn.pdmInputZeroEnable);
  assign avail[6] = ~(altFn.serialRxOneEnable | altFn.pdmInputOneEnable);
  assign avail[7] = ~(altFn.pdmInputZeroEnable | altFn.pdmInputOneEnable
                      | altFn.pdmAlternateClock | altFn.reducedRateStrobeEnable);

  assign linked = st.remotePinLinkEnable & avail;

  assign orChain[0] = 8'h00;

  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi++) begin : g_pin
      logic inActive;
      logic isInput;
      // Inverted on the way in, so the OR below sees the active level.
      assign inActive = st.sync2[gi] ^ st.remotePinInvert[gi];
      assign isInput  = linked[gi] & ~st.pinOutputEnable[gi];
      assign orChain[gi+1] = orChain[gi]
                             | (isInput & inActive ? st.pinPortMap[gi] : 8'h00);
      // Inverted after the OR of the mapped ports, toward the pin.
      assign drvBits[gi] = linked[gi]
                           ? (|(st.virtualPortState & st.pinPortMap[gi]))
                             ^ st.remotePinInvert[gi]
                           : plainPinOut[gi];
      // Input-enable plays no part for a linked pin.
      assign dirBits[gi] = linked[gi] ? st.pinOutputEnable[gi] : plainPinDrive[gi];

      a_pin_direction: assert property (@(posedge mclk) disable iff (!rst_n)
        linked[gi] |=> (pinOeN[gi] == !$past(st.pinOutputEnable[gi])))
        else $error("Linked pin direction does not follow output enable.");
    end
  endgenerate

  assign localIn = orChain[NPINS];

  // Local and remote requests toward the port state.
  assign masterSet = (localIn | remoteSet) & ~st.virtualPortState;
  assign masterClr = (st.pendClr | (st.prevLocal & ~localIn) | remoteClr)
                     & st.virtualPortState;
  assign slaveSet  = localIn & ~st.virtualPortState;
  assign slaveClr  = st.prevLocal & ~localIn & st.virtualPortState;
  assign remoteSet = linkIn.reqValid ? linkIn.reqSet : 8'h00;
  assign remoteClr = linkIn.reqValid ? linkIn.reqClr : 8'h00;
  // Bits still wanted locally or re-set during the query are never cleared.
  assign clearBits = st.queryMask & ~st.rejAcc & ~localIn
                     & ~(linkIn.respValid ? linkIn.respReject : 8'h00);

  assign apbSetup  = psel & ~penable;
  assign apbAccess = psel & penable;
  assign mapHit    = (paddr >= ADDR_MAP0) && (paddr <= ADDR_MAP7) && (paddr[1:0] == 2'b00);
  assign mapIdx    = 3'(paddr[5:2] - MAP_INDEX0);

  always_comb begin
    logic known;
    known = 1'b0;
    nxt = st;
    nxt.sync1 = pinIn;
    nxt.sync2 = st.sync1;
    nxt.prevLocal = localIn;
    nxt.pinOut = drvBits;
    nxt.pinOeN = ~dirBits;
    nxt.linkOut = '0;

    if (paddr == ADDR_STATE) begin
      known = 1'b1;
    end else if (paddr == ADDR_LINKEN) begin
      known = 1'b1;
    end else if (paddr == ADDR_OUTEN) begin
      known = 1'b1;
    end else if (paddr == ADDR_INVERT) begin
      known = 1'b1;
    end else if (mapHit) begin
      known = 1'b1;
    end

    // Read data is caught in the setup phase so the access phase needs no wait.
    if (apbSetup) begin
      nxt.prdata = 32'h0000_0000;
      if (paddr == ADDR_STATE) begin
        nxt.prdata[7:0] = st.virtualPortState;
      end else if (paddr == ADDR_LINKEN) begin
        nxt.prdata[7:0] = st.remotePinLinkEnable;
      end else if (paddr == ADDR_OUTEN) begin
        nxt.prdata[7:0] = st.pinOutputEnable;
      end else if (paddr == ADDR_INVERT) begin
        nxt.prdata[7:0] = st.remotePinInvert;
      end else if (mapHit) begin
        nxt.prdata[7:0] = st.pinPortMap[mapIdx];
      end
    end

    // A write to the port state address is accepted but stores nothing.
    if (apbAccess && pwrite && pstrb[0]) begin
      if (paddr == ADDR_LINKEN) begin
        nxt.remotePinLinkEnable = pwdata[7:0];
      end else if (paddr == ADDR_OUTEN) begin
        nxt.pinOutputEnable = pwdata[7:0];
      end else if (paddr == ADDR_INVERT) begin
        nxt.remotePinInvert = pwdata[7:0];
      end else if (mapHit) begin
        nxt.pinPortMap[mapIdx] = pwdata[7:0];
      end
    end

    // Link traffic runs on its own from here on, with no host access involved.
    if (nodeIsMaster) begin
      case (st.fsm)
        FSM_IDLE: begin
          if (masterSet != 8'h00) begin
            nxt.virtualPortState = st.virtualPortState | masterSet;
            nxt.linkOut.cmdValid = 1'b1;
            nxt.linkOut.cmdKind = CMD_UPDATE;
            nxt.linkOut.cmdData = st.virtualPortState | masterSet;
            nxt.pendClr = masterClr & ~masterSet;
          end else if (masterClr != 8'h00) begin
            nxt.linkOut.cmdValid = 1'b1;
            nxt.linkOut.cmdKind = CMD_CLRQ;
            nxt.linkOut.cmdData = masterClr;
            nxt.queryMask = masterClr;
            nxt.rejAcc = 8'h00;
            nxt.pendClr = 8'h00;
            nxt.waitCnt = QUERY_WAIT;
            nxt.fsm = FSM_QUERY;
          end else begin
            nxt.pendClr = 8'h00;
          end
        end
        FSM_QUERY: begin
          nxt.waitCnt = st.waitCnt - 8'h01;
          nxt.pendClr = (st.pendClr | remoteClr | (st.prevLocal & ~localIn))
                        & ~st.queryMask;
          nxt.rejAcc = st.rejAcc | masterSet;
          if (masterSet != 8'h00) begin
            nxt.virtualPortState = st.virtualPortState | masterSet;
            nxt.linkOut.cmdValid = 1'b1;
            nxt.linkOut.cmdKind = CMD_UPDATE;
            nxt.linkOut.cmdData = st.virtualPortState | masterSet;
          end else if (linkIn.respValid || st.waitCnt == 8'h00) begin
            // Silence until the wait runs out counts as acceptance.
            nxt.fsm = FSM_IDLE;
            nxt.virtualPortState = st.virtualPortState & ~clearBits;
            if (clearBits != 8'h00) begin
              nxt.linkOut.cmdValid = 1'b1;
              nxt.linkOut.cmdKind = CMD_UPDATE;
              nxt.linkOut.cmdData = st.virtualPortState & ~clearBits;
            end
          end
        end
        default: nxt.fsm = FSM_IDLE;
      endcase
    end else begin
      nxt.fsm = FSM_IDLE;
      if (linkIn.cmdValid && linkIn.cmdKind == CMD_UPDATE) begin
        nxt.virtualPortState = linkIn.cmdData;
      end
      if (linkIn.cmdValid && linkIn.cmdKind == CMD_CLRQ) begin
        nxt.linkOut.respValid = 1'b1;
        nxt.linkOut.respReject = linkIn.cmdData & localIn;
      end
      if ((slaveSet | slaveClr) != 8'h00) begin
        nxt.linkOut.reqValid = 1'b1;
        nxt.linkOut.reqSet = slaveSet;
        nxt.linkOut.reqClr = slaveClr;
      end
    end

    pslverr = apbAccess & ~known;
    if (!rst_n) begin
      nxt = STATE_RST;
    end
  end

  always_ff @(posedge mclk) begin
    st <= nxt;
  end

  assign prdata  = st.prdata;
  assign pready  = 1'b1;
  assign pinOut  = st.pinOut;
  assign pinOeN  = st.pinOeN;
  assign linkOut = st.linkOut;

  a_master_set_update: assert property (@(posedge mclk) disable iff (!rst_n)
    (nodeIsMaster && st.fsm == FSM_IDLE && masterSet != 8'h00)
    |=> (linkOut.cmdValid && linkOut.cmdKind == CMD_UPDATE
         && ((linkOut.cmdData & $past(masterSet)) == $past(masterSet))))
    else $error("Set request did not produce an update.");

  a_clear_query_sent: assert property (@(posedge mclk) disable iff (!rst_n)
    (nodeIsMaster && $rose(st.fsm == FSM_QUERY))
    |-> (linkOut.cmdValid && linkOut.cmdKind == CMD_CLRQ && linkOut.cmdData == st.queryMask))
    else $error("Entering a query without a clear query message.");

  a_query_bounded: assert property (@(posedge mclk) disable iff (!rst_n)
    (nodeIsMaster && st.fsm == FSM_QUERY) |-> ##[0:300] (st.fsm == FSM_IDLE))
    else $error("Clear query never resolved.");

  a_reject_keeps_ports: assert property (@(posedge mclk) disable iff (!rst_n)
    (nodeIsMaster && st.fsm == FSM_QUERY && linkIn.respValid && masterSet == 8'h00
     && (linkIn.respReject & st.queryMask) == st.queryMask)
    |=> ((st.virtualPortState & $past(st.queryMask)) == $past(st.queryMask)))
    else $error("Rejected clear changed a port.");

  a_slave_reject_answer: assert property (@(posedge mclk) disable iff (!rst_n)
    (!nodeIsMaster && linkIn.cmdValid && linkIn.cmdKind == CMD_CLRQ)
    |=> (linkOut.respValid && linkOut.respReject == $past(linkIn.cmdData & localIn)))
    else $error("Slave clear answer wrong.");

  a_slave_takes_update: assert property (@(posedge mclk) disable iff (!rst_n)
    (!nodeIsMaster && linkIn.cmdValid && linkIn.cmdKind == CMD_UPDATE)
    |=> (st.virtualPortState == $past(linkIn.cmdData)))
    else $error("Slave did not take the port update.");

  a_master_pin0_off: assert property (@(posedge mclk) disable iff (!rst_n)
    nodeIsMaster |-> !linked[0])
    else $error("Pin 0 linked on a master.");

  a_state_write_ignored: assert property (@(posedge mclk) disable iff (!rst_n)
    (apbAccess && pwrite && paddr == ADDR_STATE
     && (nodeIsMaster ? (st.fsm == FSM_IDLE && masterSet == 8'h00) : !linkIn.cmdValid))
    |=> $stable(st.virtualPortState))
    else $error("Write changed the port state register.");

  a_unmapped_error: assert property (@(posedge mclk) disable iff (!rst_n)
    (apbAccess && paddr == 8'h30) |-> (pslverr && pready))
    else $error("Unmapped access not flagged.");

endmodule

// ### tb/gvp_far_node.sv
// Far nodes of the link: they raise port requests and answer clear queries.
`timescale 1ns/1ps
module gvp_far_node
  import gvp_pkg::*;
(
  // Clock
  input  wire logic      mclk,
  // Link messages
  input  wire gvp_link_t linkOut,
  output gvp_link_t      linkIn
);
  logic [7:0] holdMask = 8'h00;
  int         ansDelay = 0;
  logic       reqV     = 1'b0;
  logic       respV    = 1'b0;
  logic [7:0] reqS;
  logic [7:0] reqC;
  logic [7:0] respR;
  logic [7:0] noise;
  logic [7:0] q;
  // Idle fields carry changing noise so stale data never passes for a message.
  always @(posedge mclk) noise <= 8'($urandom);
  assign linkIn = '{cmdValid: 1'b0, cmdKind: CMD_NONE, cmdData: noise, reqValid: reqV,
                    reqSet: reqV ? reqS : noise, reqClr: reqV ? reqC : ~noise,
                    respValid: respV, respReject: respV ? respR : ~noise};
  task automatic request(input logic [7:0] s, input logic [7:0] c);
    reqS <= s;
    reqC <= c;
    reqV <= 1'b1;
    @(posedge mclk);
    reqV <= 1'b0;
  endtask
  initial forever begin
    @(posedge mclk);
    if (linkOut.cmdValid === 1'b1 && linkOut.cmdKind === CMD_CLRQ) begin
      q = linkOut.cmdData & holdMask;
      repeat (ansDelay) @(posedge mclk);
      respR <= q;
      respV <= 1'b1;
      @(posedge mclk);
      respV <= 1'b0;
    end
  end
endmodule

// ### tb/test_gvp_link.sv
// Self-checking bench of the virtual port link in the master role.
`timescale 1ns/1ps
module test_gvp_link import gvp_pkg::*;;
  logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0]  paddr, pinIn, pinOut, pinOeN, plainPinOut, plainPinDrive;
  logic [31:0] pwdata, prdata, r, v;
  logic [3:0]  pstrb;
  gvp_altfn_t  altFn;
  gvp_link_t   linkIn, linkOut;
  logic [9:0]  cmdQ[$];
  logic [7:0]  cfgM[12];
  int          mState;
  int          miscompares = 0;
  int          checksDone  = 0;

  gvp_link #(.QUERY_WAIT(8'h08)) uut (
    .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .nodeIsMaster(1'b1), .altFn(altFn), .pinIn(pinIn), .pinOut(pinOut),
    .pinOeN(pinOeN), .plainPinOut(plainPinOut), .plainPinDrive(plainPinDrive),
    .linkIn(linkIn), .linkOut(linkOut));
  gvp_far_node far (.mclk(mclk), .linkOut(linkOut), .linkIn(linkIn));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) if (linkOut.cmdValid === 1'b1) cmdQ.push_back({linkOut.cmdKind,
                                                                         linkOut.cmdData});

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chkVal(input logic [32:0] got, input logic [32:0] exp);
    checksDone++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask
  // Waits boundedly for the next link command, then compares kind and data.
  task automatic chkCmd(input logic [1:0] k, input logic [7:0] d);
    int n = 0;
    while (cmdQ.size() == 0 && n < 40) begin
      @(posedge mclk);
      n++;
    end
    checksDone++;
    if (cmdQ.size() == 0 || cmdQ[0] !== {k, d}) begin
      miscompares++;
      $display("ERROR %0t link command missing or not %h", $time, {k, d});
    end
    if (cmdQ.size() > 0) void'(cmdQ.pop_front());
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  initial begin
    #(100 * 6000);
    miscompares++;
    give_verdict();
  end

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hF;
    pinIn = 8'h01;
    altFn = '1;
    plainPinOut = 8'h00;
    plainPinDrive = 8'h00;
    void'($urandom(33));
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    plainPinOut <= 8'($urandom);
    plainPinDrive <= 8'($urandom);
    @(posedge mclk);
    mState = 0;
    for (int a = 0; a < 8'h34; a += 4) begin
      apb(1'b0, 8'(a), 32'h0, 4'hF);
      chkVal({e, r}, (a == 8'h30) ? 33'h1_0000_0000 : 33'h0);
    end
    // Every pin is unavailable here, so random settings must not move any port.
    for (int a = 4; a < 8'h30; a += 4) begin
      v = $urandom;
      cfgM[a / 4] = v[7:0];
      apb(1'b1, 8'(a), v, 4'hF);
      apb(1'b0, 8'(a), 32'h0, 4'hF);
      chkVal({e, r}, {25'h0, v[7:0]});
    end
    apb(1'b1, ADDR_STATE, 32'hFF, 4'hF);
    apb(1'b1, ADDR_OUTEN, ~v, 4'hE);
    apb(1'b0, ADDR_OUTEN, 32'h0, 4'hF);
    chkVal({e, r}, {25'h0, cfgM[2]});
    apb(1'b0, ADDR_STATE, 32'h0, 4'hF);
    chkVal({e, r}, 33'h0);
    chkVal({31'h0, pinOut[3], pinOeN[3]}, {31'h0, plainPinOut[3], ~plainPinDrive[3]});
    chkVal(33'(cmdQ.size()), 33'h0);
    for (int a = 4; a < 8'h30; a += 4) apb(1'b1, 8'(a), 32'h0, 4'hF);
    altFn <= '0;
    far.request(8'h04, 8'h00);
    mState = mState | 4;
    chkCmd(CMD_UPDATE, 8'(mState));
    far.holdMask = 8'h04;
    far.ansDelay = 3;
    far.request(8'h00, 8'h04);
    chkCmd(CMD_CLRQ, 8'h04);
    repeat (12) @(posedge mclk);
    apb(1'b0, ADDR_STATE, 32'h0, 4'hF);
    chkVal({e, r} | 33'(cmdQ.size() << 8), 33'(mState));
    far.holdMask = 8'h00;
    far.ansDelay = 0;
    far.request(8'h00, 8'h04);
    chkCmd(CMD_CLRQ, 8'h04);
    mState = mState & ~4;
    chkCmd(CMD_UPDATE, 8'(mState));
    // Pin 0 is linked and held high, yet a master must never let it reach a port.
    apb(1'b1, ADDR_MAP0, 32'h01, 4'hF);
    apb(1'b1, ADDR_MAP0 + 8'h04, 32'h0C, 4'hF);
    apb(1'b1, ADDR_MAP0 + 8'h18, 32'h04, 4'hF);
    apb(1'b1, ADDR_OUTEN, 32'h02, 4'hF);
    apb(1'b1, ADDR_LINKEN, 32'h43, 4'hF);
    repeat (6) @(posedge mclk);
    chkVal(33'(cmdQ.size()), 33'h0);
    pinIn <= 8'h41;
    mState = mState | 4;
    chkCmd(CMD_UPDATE, 8'(mState));
    repeat (3) @(posedge mclk);
    chkVal({31'h0, pinOut[1], pinOeN[1]}, {31'h0, (mState & 'hC) != 0, 1'b0});
    apb(1'b1, ADDR_INVERT, 32'h40, 4'hF);
    chkCmd(CMD_CLRQ, 8'h04);
    mState = mState & ~4;
    chkCmd(CMD_UPDATE, 8'(mState));
    apb(1'b1, ADDR_INVERT, 32'h42, 4'hF);
    repeat (3) @(posedge mclk);
    chkVal({32'h0, pinOut[1]}, {32'h0, (mState & 'hC) == 0});
    give_verdict();
  end
endmodule
